//--- tms_chan.v
// Limit comparators and flags of one measurement channel.
`timescale 1ns/100ps
module tms_chan (
  input  wire       mclk,
  input  wire       rst,
  input  wire       upd,
  input  wire       rd_clr,
  input  wire       critical_limit_mode,
  input  wire [7:0] temp,
  input  wire [7:0] high_lim,
  input  wire [7:0] low_lim,
  input  wire [7:0] crit_lim,
  input  wire [7:0] hyst,
  output wire       out_now,
  output reg        high_q,
  output reg        low_q,
  output reg        crit_q
);
  reg        hi_now_q;
  reg        lo_now_q;
  wire [7:0] hi_rel;
  wire [7:0] cr_rel;
  wire       above_hi;
  wire       below_lo;

  // Release thresholds saturate at zero so a large hysteresis cannot wrap.
  assign hi_rel   = (high_lim > hyst) ? (high_lim - hyst) : 8'h00;
  assign cr_rel   = (crit_lim > hyst) ? (crit_lim - hyst) : 8'h00;
  assign above_hi = temp > high_lim;
  assign below_lo = temp < low_lim;
  assign out_now  = above_hi | below_lo;

  // Latched flags: a new excursion wins over a clearing read in the same cycle.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      high_q   <= 1'b0;
      low_q    <= 1'b0;
      crit_q   <= 1'b0;
      hi_now_q <= 1'b0;
      lo_now_q <= 1'b0;
    end
    else
    begin
      if (upd)
      begin
        crit_q   <= (temp > crit_lim) | (crit_q & (temp > cr_rel));
        hi_now_q <= above_hi;
        lo_now_q <= below_lo;
      end
      if (critical_limit_mode)
      begin
        if (upd)
          high_q <= above_hi | (high_q & (temp > hi_rel));
      end
      else if (upd && above_hi)
        high_q <= 1'b1;
      else if (rd_clr && !hi_now_q)
        high_q <= 1'b0;
      if (upd && below_lo)
        low_q <= 1'b1;
      else if (rd_clr && !lo_now_q)
        low_q <= 1'b0;
    end
  end
endmodule // tms_chan

//--- tms_consts.vh
// Register map, field positions, reset values and timing constants of the temperature monitor status block.
// Overview of operation
// - Flag register at pointer 02h is read only, writes ignored, resets to zero.
// - Bit D7 reads 1 while a conversion runs; first conversion starts right after reset.
// - Bit D2 latches when an open remote diode is seen during a remote conversion.
// - Bit D1 sets above remote critical limit, clears at limit minus hysteresis.
// - Bit D0 sets above local critical limit, clears at limit minus hysteresis.
// - In alert mode D6 and D4 latch when high limits are exceeded.
// - In second over-temperature mode D6 and D4 follow high limits with hysteresis.
// - D5 and D3 latch below low limits in either pin mode.
// - Latched flags clear on flag read or reset, only if cause has gone.
// - Non-latched flags show current state, update at conversion end, ignore reads.
// - Flag reads never release the alert output; alert response release does.
// - In alert mode a rising alert-class flag drives the alert output low.
// - Configuration written at 09h, read at 03h, resets to 00h.
// - Bit 7 masks the alert pin in alert mode only; alert state is kept.
// - Bit 6 stops conversions at once; clearing it resumes continuous conversion.
// - While shut down, a one-shot write starts a single conversion.
// - Bit 5 set makes the output a second over-temperature output from high flags.
// - Bit 2 selects standard or extended result range.
// - Register 1Ah sets local resolution and conversion time 12.5 to 100 ms.
// - Resolution register resets to 1Ch; host keeps bits 2-4 one, 5-7 zero.
// - Hysteresis register at 21h, unsigned, resets to 0Ah.
// - Any write to 0Fh while shut down converts both channels once, stores nothing.
`ifndef TMS_CONSTS_VH
`define TMS_CONSTS_VH
`define TMS_PTR_FLAGS    8'h02
`define TMS_PTR_CFG_RD   8'h03
`define TMS_PTR_CFG_WR   8'h09
`define TMS_PTR_ONESHOT  8'h0F
`define TMS_PTR_RES      8'h1A
`define TMS_PTR_HYST     8'h21
`define TMS_FLAGS_RST    8'h00
`define TMS_CFG_RST      8'h00
`define TMS_CFG_WMASK    8'hE4
`define TMS_RES_RST      8'h1C
`define TMS_HYST_RST     8'h0A
`define TMS_CFG_MASK     7
`define TMS_CFG_SD       6
`define TMS_CFG_ALTH     5
`define TMS_CFG_RANGE    2
`define TMS_MCLK_NS      5
`define TMS_CONV9_US     12500
`define TMS_REMOTE_US    12500
`define TMS_IDLE_US      1000
`define TMS_FAULT_QUEUE  8'h01
`endif

//--- tms_host.sv
// Register host model: byte writes, byte reads and the alert response strobe.
`timescale 1ns/100ps
module tms_host (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            ara_ack
);
  // Idle from time zero so nothing is taken before the first request.
  initial
  begin
    {reg_addr, reg_wdata} = 16'h0000;
    {reg_wr, reg_rd, ara_ack} = 3'h0;
  end

  // Callers keep reserved bits at their required values unless a case checks they are dropped.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // The data is taken at the edge where the valid pulse is seen, under a bounded wait.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!reg_rvalid && n < 8);
    // A read that is never answered returns unknowns so the caller's compare fails.
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask

  // Flag reads never release the pin, so this strobe is the host's only way to do it.
  task automatic ara();
    @(posedge mclk);
    ara_ack <= 1'b1;
    @(posedge mclk);
    ara_ack <= 1'b0;
  endtask
endmodule // tms_host

//--- tms_sync.v
// Two-stage synchroniser for one level from outside the clock domain.
`timescale 1ns/100ps
module tms_sync (
  input  wire mclk,
  input  wire rst,
  input  wire din,
  output reg  dout_q
);
  reg meta_q;

  // The first stage feeds only the second stage.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      dout_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule // tms_sync

//--- tms_top.v
// Status flags, configuration, resolution, hysteresis and conversion sequencing of the monitor.
`timescale 1ns/100ps
`include "tms_consts.vh"
module tms_top #(
  parameter [31:0] CONV9_CYC   = (`TMS_CONV9_US * 1000) / `TMS_MCLK_NS,
  parameter [31:0] REMOTE_CYC  = (`TMS_REMOTE_US * 1000) / `TMS_MCLK_NS,
  parameter [31:0] IDLE_CYC    = (`TMS_IDLE_US * 1000) / `TMS_MCLK_NS,
  parameter [7:0]  FAULT_QUEUE = `TMS_FAULT_QUEUE
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  input  wire       ara_ack,
  input  wire [7:0] adc_temp,
  input  wire       adc_open,
  input  wire [7:0] local_high_lim,
  input  wire [7:0] local_low_lim,
  input  wire [7:0] local_critical_limit,
  input  wire [7:0] remote_high_lim,
  input  wire [7:0] remote_low_lim,
  input  wire [7:0] remote_critical_limit,
  output wire       adc_conv,
  output wire       adc_chan,
  output wire [1:0] adc_res,
  output wire       adc_ext_range,
  input  wire       shared_alarm_output_din,
  output wire       shared_alarm_output_dout,
  output reg        shared_alarm_output_oe_n,
  output wire       alarm_line_level
);
  // Sequencer states.
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_LOC  = 2'd1;
  localparam [1:0] S_REM  = 2'd2;
  localparam [1:0] S_GAP  = 2'd3;

  reg  [7:0]  cfg_q;
  reg  [7:0]  res_q;
  reg  [7:0]  hyst_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [31:0] cnt_q;
  reg  [31:0] cnt_d;
  reg         single_q;
  reg         single_d;
  reg         upd_loc;
  reg         upd_rem;
  reg         open_q;
  reg         open_now_q;
  reg  [4:0]  prev_q;
  reg  [7:0]  cons_q;
  reg         alert_q;
  wire        shutdown_ctl;
  wire        pin_function_select;
  wire        alert_mask;
  wire        precision_select_hi;
  wire        precision_select_lo;
  wire        busy;
  wire        rd_clr;
  wire        oneshot_wr;
  wire [31:0] loc_cyc;
  wire        loc_high;
  wire        loc_low;
  wire        loc_crit;
  wire        rem_high;
  wire        rem_low;
  wire        rem_crit;
  wire        loc_oor;
  wire        rem_oor;
  wire [4:0]  alert_flags;
  wire        alert_rise;
  wire        armed;
  wire        alarm_drive;
  wire [7:0]  flags;

  // Configuration fields that steer the rest of the block.
  assign shutdown_ctl        = cfg_q[`TMS_CFG_SD];
  assign pin_function_select = cfg_q[`TMS_CFG_ALTH];
  assign alert_mask          = cfg_q[`TMS_CFG_MASK];
  assign precision_select_hi = res_q[1];
  assign precision_select_lo = res_q[0];

  // Register port decode; a flag read is the clearing event for latched flags.
  assign rd_clr     = reg_rd && (reg_addr == `TMS_PTR_FLAGS);
  assign oneshot_wr = reg_wr && (reg_addr == `TMS_PTR_ONESHOT);

  // Local conversion time doubles with each resolution step from the 9-bit time.
  assign loc_cyc = CONV9_CYC << {precision_select_hi, precision_select_lo};

  // Converter controls are driven straight from sequencer state and settings.
  assign busy          = (state_q == S_LOC) || (state_q == S_REM);
  assign adc_conv      = busy;
  assign adc_chan      = (state_q == S_REM);
  assign adc_res       = {precision_select_hi, precision_select_lo};
  assign adc_ext_range = cfg_q[`TMS_CFG_RANGE];

  // Writable registers. Reserved configuration bits are not stored and read zero.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q  <= `TMS_CFG_RST;
      res_q  <= `TMS_RES_RST;
      hyst_q <= `TMS_HYST_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TMS_PTR_CFG_WR: cfg_q  <= reg_wdata & `TMS_CFG_WMASK;
        `TMS_PTR_RES:    res_q  <= reg_wdata;
        `TMS_PTR_HYST:   hyst_q <= reg_wdata;
        default:         cfg_q  <= cfg_q;
      endcase
    end
  end

  // Read data is captured one edge after the strobe; unmapped pointers read 00h.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          `TMS_PTR_FLAGS:  reg_rdata <= flags;
          `TMS_PTR_CFG_RD: reg_rdata <= cfg_q;
          `TMS_PTR_RES:    reg_rdata <= res_q;
          `TMS_PTR_HYST:   reg_rdata <= hyst_q;
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Conversion sequencer: local then remote, then an idle gap, unless shut down.
  // Setting shutdown aborts a free-running conversion at once rather than
  // finishing it; a one-shot conversion in progress is allowed to complete.
  always @*
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    single_d = single_q;
    upd_loc  = 1'b0;
    upd_rem  = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        if (!shutdown_ctl)
        begin
          state_d = S_LOC;
          cnt_d   = loc_cyc;
        end
        else if (oneshot_wr)
        begin
          state_d  = S_LOC;
          cnt_d    = loc_cyc;
          single_d = 1'b1;
        end
      end
      S_LOC:
      begin
        if (shutdown_ctl && !single_q)
          state_d = S_IDLE;
        else if (cnt_q <= 32'd1)
        begin
          upd_loc = 1'b1;
          state_d = S_REM;
          cnt_d   = REMOTE_CYC;
        end
        else
          cnt_d = cnt_q - 32'd1;
      end
      S_REM:
      begin
        if (shutdown_ctl && !single_q)
          state_d = S_IDLE;
        else if (cnt_q <= 32'd1)
        begin
          upd_rem = 1'b1;
          if (single_q || shutdown_ctl)
          begin
            state_d  = S_IDLE;
            single_d = 1'b0;
          end
          else
          begin
            state_d = S_GAP;
            cnt_d   = IDLE_CYC;
          end
        end
        else
          cnt_d = cnt_q - 32'd1;
      end
      S_GAP:
      begin
        if (shutdown_ctl)
          state_d = S_IDLE;
        else if (cnt_q <= 32'd1)
        begin
          state_d = S_LOC;
          cnt_d   = loc_cyc;
        end
        else
          cnt_d = cnt_q - 32'd1;
      end
      default:
      begin
        state_d  = S_IDLE;
        cnt_d    = 32'd0;
        single_d = 1'b0;
      end
    endcase
  end

  // Reset enters the gap with an empty count, so the first conversion starts
  // on the first edge after release.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q  <= S_GAP;
      cnt_q    <= 32'd0;
      single_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      single_q <= single_d;
    end
  end

  // Per-channel comparators and flags.
  tms_chan u_local (
    .mclk       (mclk),
    .rst        (rst),
    .upd        (upd_loc),
    .rd_clr     (rd_clr),
    .critical_limit_mode (pin_function_select),
    .temp       (adc_temp),
    .high_lim   (local_high_lim),
    .low_lim    (local_low_lim),
    .crit_lim   (local_critical_limit),
    .hyst       (hyst_q),
    .out_now    (loc_oor),
    .high_q     (loc_high),
    .low_q      (loc_low),
    .crit_q     (loc_crit)
  );

  tms_chan u_remote (
    .mclk       (mclk),
    .rst        (rst),
    .upd        (upd_rem),
    .rd_clr     (rd_clr),
    .critical_limit_mode (pin_function_select),
    .temp       (adc_temp),
    .high_lim   (remote_high_lim),
    .low_lim    (remote_low_lim),
    .crit_lim   (remote_critical_limit),
    .hyst       (hyst_q),
    .out_now    (rem_oor),
    .high_q     (rem_high),
    .low_q      (rem_low),
    .crit_q     (rem_crit)
  );

  // Open-diode flag is only sampled at the end of a remote conversion.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      open_q     <= 1'b0;
      open_now_q <= 1'b0;
    end
    else
    begin
      if (upd_rem)
        open_now_q <= adc_open;
      if (upd_rem && adc_open)
        open_q <= 1'b1;
      else if (rd_clr && !open_now_q)
        open_q <= 1'b0;
    end
  end

  // Flag register image, D7 down to D0.
  assign flags = {busy, loc_high, loc_low, rem_high, rem_low, open_q, rem_crit, loc_crit};

  // Alert-class flags and their rising edges.
  assign alert_flags = {loc_high, loc_low, rem_high, rem_low, open_q};
  assign alert_rise  = |(alert_flags & ~prev_q);
  assign armed       = (cons_q >= FAULT_QUEUE);

  // Consecutive out-of-limit conversions; any clean conversion restarts the run.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 5'h00;
      cons_q <= 8'h00;
    end
    else
    begin
      prev_q <= alert_flags;
      if (upd_loc || upd_rem)
      begin
        if ((upd_loc && loc_oor) || (upd_rem && (rem_oor || adc_open)))
          cons_q <= (cons_q == 8'hFF) ? cons_q : cons_q + 8'h01;
        else
          cons_q <= 8'h00;
      end
    end
  end

  // Alert state survives flag reads and is only released by the alert
  // response; a new rise in the release cycle keeps it set.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      alert_q <= 1'b0;
    else if (!pin_function_select && alert_rise && armed)
      alert_q <= 1'b1;
    else if (ara_ack)
      alert_q <= 1'b0;
  end

  // Mask hides the alert only in alert mode; the pin is open drain.
  assign alarm_drive = pin_function_select ? (loc_high | rem_high)
                                           : (alert_q & ~alert_mask);

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      shared_alarm_output_oe_n <= 1'b1;
    else
      shared_alarm_output_oe_n <= ~alarm_drive;
  end

  // Open drain only ever pulls low.
  assign shared_alarm_output_dout = 1'b0;

  // The wired line can be held low by other devices, so its level is resynchronised.
  tms_sync u_line_sync (
    .mclk   (mclk),
    .rst    (rst),
    .din    (shared_alarm_output_din),
    .dout_q (alarm_line_level)
  );
endmodule // tms_top

//--- tms_top_properties.sv
// Concurrent checks on the register port, sequencer and alarm pin of the status block.
`timescale 1ns/100ps
module tms_top_properties (
  input wire logic       mclk, rst, reg_wr, reg_rd, reg_rvalid, ara_ack,
  input wire logic       adc_conv, adc_chan, adc_ext_range,
  input wire logic       shared_alarm_output_dout, shared_alarm_output_oe_n,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [1:0] adc_res
);
  logic [7:0] cfg_q, res_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Shadow copies of the configuration and resolution registers; reserved control bits are dropped on purpose.
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      cfg_q <= 8'h00;
      res_q <= 8'h1C;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h09) cfg_q <= reg_wdata & 8'hE4;
      if (reg_addr == 8'h1A) res_q <= reg_wdata;
    end

  // One-shot request while stopped and idle, and the local phase it must open.
  sequence s_oneshot;
    cfg_q[6] && !adc_conv && reg_wr && reg_addr == 8'h0F;
  endsequence
  sequence s_local;
    adc_conv && !adc_chan;
  endsequence

  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_cfg_readback: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata == cfg_q)
    else $error("control readback wrong");
  a_res_readback: assert property (reg_rd && reg_addr == 8'h1A |=> reg_rdata == res_q)
    else $error("precision readback wrong");
  a_range_out: assert property (adc_ext_range == cfg_q[2]) else $error("range output wrong");
  a_res_out: assert property (adc_res == res_q[1:0]) else $error("precision output wrong");
  a_stop_now: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[6] && !cfg_q[6] |-> ##[1:2] !adc_conv)
    else $error("conversion not stopped");
  a_oneshot_start: assert property (s_oneshot |=> s_local) else $error("one-shot not started");
  a_alert_release: assert property (ara_ack && !cfg_q[5] |-> ##2 shared_alarm_output_oe_n)
    else $error("alarm not released");
  a_mask_holds: assert property ((cfg_q[7] && !cfg_q[5]) [*2] |-> shared_alarm_output_oe_n)
    else $error("masked alarm driven");
  a_drive_low: assert property (shared_alarm_output_dout == 1'b0) else $error("pin driven high");
  a_busy_start: assert property ($fell(rst) |-> ##[1:2] adc_conv) else $error("no conversion after reset");
endmodule // tms_top_properties

bind tms_top tms_top_properties u_props (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .ara_ack(ara_ack), .adc_conv(adc_conv), .adc_chan(adc_chan),
  .adc_ext_range(adc_ext_range), .shared_alarm_output_dout(shared_alarm_output_dout),
  .shared_alarm_output_oe_n(shared_alarm_output_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .adc_res(adc_res));

//--- tms_top_tb.sv
// Self-checking bench of the status block: registers, flags, alarm pin and conversion sequencing.
`timescale 1ns/100ps
module tms_top_tb;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] ra; logic [7:0] exp;} tms_row_t;
  localparam logic [31:0] C9 = 32'h14;
  localparam logic [31:0] RC = 32'h14;
  logic       mclk = 1'b0, rst = 1'b1, adc_open = 1'b0;
  logic [7:0] adc_temp = 8'h00, lt = 8'h1E, rt = 8'h1E, rd_v;
  logic [7:0] lhi = 8'h32, llo = 8'h00, lcr = 8'hFF, rhi = 8'h32, rlo = 8'h00, rcr = 8'hFF;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] adc_res;
  logic       reg_wr, reg_rd, reg_rvalid, ara_ack, adc_conv, adc_chan, adc_ext_range, oe_n, line_lvl;
  wire        din = oe_n; // Pulled-up line: high whenever the pin is released.
  int         fail_count = 0, comparisons = 0, n;
  // Reset values, readback masks, a read-only and an unmapped place.
  tms_row_t   rows [9] = '{'{1'b0, 8'h00, 8'h00, 8'h03, 8'h00}, '{1'b0, 8'h00, 8'h00, 8'h1A, 8'h1C},
    '{1'b0, 8'h00, 8'h00, 8'h21, 8'h0A}, '{1'b1, 8'h09, 8'hFF, 8'h03, 8'hE4}, '{1'b1, 8'h09, 8'h00, 8'h03, 8'h00},
    '{1'b1, 8'h1A, 8'h1F, 8'h1A, 8'h1F}, '{1'b1, 8'h21, 8'h05, 8'h21, 8'h05}, '{1'b1, 8'h03, 8'h55, 8'h03, 8'h00},
    '{1'b1, 8'h0F, 8'h33, 8'h0F, 8'h00}};

  tms_top #(.CONV9_CYC(C9), .REMOTE_CYC(RC), .IDLE_CYC(32'h0A), .FAULT_QUEUE(8'h01)) dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ara_ack(ara_ack), .adc_temp(adc_temp), .adc_open(adc_open),
    .local_high_lim(lhi), .local_low_lim(llo), .local_critical_limit(lcr), .remote_high_lim(rhi),
    .remote_low_lim(rlo), .remote_critical_limit(rcr), .adc_conv(adc_conv), .adc_chan(adc_chan),
    .adc_res(adc_res), .adc_ext_range(adc_ext_range), .shared_alarm_output_din(din),
    .shared_alarm_output_dout(), .shared_alarm_output_oe_n(oe_n), .alarm_line_level(line_lvl));
  tms_host host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .ara_ack(ara_ack));

  // Clock, and the converter result of whichever channel is being measured.
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) adc_temp <= adc_chan ? rt : lt;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Set both readings, then let a whole conversion after the current one sample them.
  task automatic conv(input logic [7:0] l, input logic [7:0] r);
    int m;
    @(posedge mclk);
    lt <= l;
    rt <= r;
    m = 0;
    while (adc_conv && m < 400) begin step(1); m++; end
    while (!adc_conv && m < 400) begin step(1); m++; end
    while (adc_conv && m < 400) begin step(1); m++; end
    step(3);
  endtask

  // Counts busy cycles (local phase only if loc), optionally from a fresh start.
  task automatic span(input bit fresh, input bit loc, output int k);
    int m;
    m = 0;
    k = 0;
    // One edge first, so a conversion loaded on the write edge with the old setting is skipped.
    step(1);
    while (fresh && adc_conv && m < 400) begin step(1); m++; end
    while (!adc_conv && m < 400) begin step(1); m++; end
    while (adc_conv && !(loc && adc_chan) && k < 400) begin step(1); k++; end
  endtask

  // Flag read with the busy bit masked off, since conversions run on meanwhile.
  task automatic rf(input logic [7:0] exp);
    host.rd(8'h02, rd_v);
    check(rd_v & 8'h7F, exp, "flags");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles the cases need.
  initial
  begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence: reset, register rows, then the awkward cases.
  initial
  begin
    step(4);
    rst <= 1'b0;
    step(2);
    check(adc_conv, 8'h01, "busy");
    host.rd(8'h02, rd_v);
    check(rd_v, 8'h80, "flags after reset");
    foreach (rows[i])
    begin
      if (rows[i].wr) host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].ra, rd_v);
      check(rd_v, rows[i].exp, "register row");
    end
    $display("test registers done");
    host.wr(8'h09, 8'h04);
    step(2);
    check(adc_ext_range, 8'h01, "range");
    host.wr(8'h09, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      host.wr(8'h1A, 8'h1C | 8'(r));
      span(1'b1, 1'b1, n);
      check(8'(n), 8'(C9 << r), "local time");
      check(adc_res, 8'(r), "precision out");
    end
    host.wr(8'h1A, 8'h1C);
    $display("test precision done");
    adc_open <= 1'b1;
    rlo <= 8'h28;
    conv(8'h3C, 8'h1E);
    rf(8'h4C);
    check(oe_n, 8'h00, "alarm low");
    check(line_lvl, 8'h00, "line level low");
    adc_open <= 1'b0;
    rlo <= 8'h00;
    conv(8'h1E, 8'h1E);
    rf(8'h4C);
    rf(8'h00);
    check(oe_n, 8'h00, "alarm after reads");
    host.ara();
    step(3);
    check(oe_n, 8'h01, "alarm released");
    host.wr(8'h09, 8'h80);
    conv(8'h3C, 8'h1E);
    rf(8'h40);
    check(oe_n, 8'h01, "masked");
    check(line_lvl, 8'h01, "line level released");
    conv(8'h1E, 8'h1E);
    rf(8'h40);
    host.wr(8'h09, 8'h00);
    step(3);
    check(oe_n, 8'h00, "state kept under mask");
    host.ara();
    $display("test alert done");
    host.wr(8'h09, 8'h20);
    conv(8'h3C, 8'h1E);
    rf(8'h40);
    rf(8'h40);
    check(oe_n, 8'h00, "second overtemp");
    conv(8'h2E, 8'h1E);
    rf(8'h40);
    conv(8'h2D, 8'h1E);
    rf(8'h00);
    check(oe_n, 8'h01, "second overtemp off");
    host.wr(8'h09, 8'h00);
    llo <= 8'h28;
    conv(8'h1E, 8'h3C);
    rf(8'h30);
    check(oe_n, 8'h00, "alarm from low and remote high");
    llo <= 8'h00;
    conv(8'h1E, 8'h1E);
    rf(8'h30);
    host.ara();
    {lhi, rhi, lcr, rcr} <= 32'hFFFF4646;
    conv(8'h47, 8'h47);
    rf(8'h03);
    conv(8'h42, 8'h42);
    rf(8'h03);
    conv(8'h41, 8'h41);
    rf(8'h00);
    $display("test thresholds done");
    host.wr(8'h09, 8'h40);
    step(2);
    check(adc_conv, 8'h00, "stopped");
    host.wr(8'h0F, 8'h5A);
    span(1'b0, 1'b0, n);
    check(8'(n), 8'(C9 + RC), "one-shot length");
    span(1'b0, 1'b0, n);
    check(8'(n), 8'h00, "back to shutdown");
    host.wr(8'h09, 8'h00);
    step(20);
    check(adc_conv, 8'h01, "resumed");
    host.wr(8'h09, 8'h84);
    rst <= 1'b1;
    step(4);
    rst <= 1'b0;
    step(2);
    host.rd(8'h03, rd_v);
    check(rd_v, 8'h00, "control after reset");
    host.rd(8'h02, rd_v);
    check(rd_v, 8'h80, "flags after reset");
    $display("test shutdown and reset done");
    report_and_stop();
  end
endmodule // tms_top_tb
